// ===== eepec_ctrl.sv
// Purpose: program/erase control logic of the on-chip eeprom
// Assumes: register port and array strobes synchronous to ref_clk
// Notes: no completion timer; software times every pulse
//
// Behaviour
// - test register readable always, writable only in special mode, else zero.
// - odd-row test bit makes operation act on all physically odd rows.
// - even-row test bit makes operation act on all even rows.
// - margin test bit selects voltage margin test condition.
// - pump-disable bit keeps charge pump off during program/erase.
// - ramp-disable bit bypasses progressive charge pump ramp-up.
// - pump-monitor bit routes pump voltage to the irq/vpp pin.
// - bulk-erase guard refuses bulk/row erase; writable if no voltage, unlocked.
// - byte/row fields decode bulk, 32-byte row or byte/word erase.
// - byte and row fields ignored when erase-select is zero.
// - byte erase outside test erases only the latched byte or word.
// - erase-select chooses programming/reading at 0, erasure at 1.
// - latch-arm arms the latches and blocks array read data.
// - size, erase and latch fields writable together or in any order.
// - voltage-apply sets only if latch-arm already set.
// - voltage-apply freezes guard, byte, row, erase and latch fields.
// - array writes ignored and latches held while voltage applied.
// - voltage-apply turns program/erase voltage on and off.
// - guard lock write-once in normal mode; freezes guard bits when set.
// - block guard bits protect 256, 256, 128, 64 and 64 byte blocks.
// - stop mode removes voltage, keeps voltage-apply, restores on exit.
`timescale 1ns/1ps
`include "eepec_regs.svh"
module eepec_ctrl
  import eepec_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // mode and power state
  input wire logic special_mode_n,
  input wire logic stopMode,
  // register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // array write strobe
  input wire logic arrayWrite,
  input wire logic arrayWide,
  input wire logic [ADDR_W-1:0] arrayAddr,
  input wire logic [15:0] arrayWdata,
  // array read gating
  output logic arrayReadBlock,
  // high voltage control
  output logic hvEnable,
  output logic pumpEnable,
  output logic pumpRampEnable,
  output logic marginTest,
  output logic pumpMonitor,
  output logic opErase,
  output eepec_size_e opSize,
  output logic oddRowSel,
  output logic evenRowSel,
  output logic opBlocked,
  output eepec_latch_s latchOut
);
  initial begin
    if (ADDR_W != 16)
      $error("eepec_ctrl serves 16-bit addresses only");
  end

  ////////////////////////////////////////////////////////////////////////////
  logic rstSync1Ff, rstSync2Ff;
  logic rstN;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync1Ff <= 1'b0;
      rstSync2Ff <= 1'b0;
    end else begin
      rstSync1Ff <= 1'b1;
      rstSync2Ff <= rstSync1Ff;
    end
  end
  assign rstN = rstSync2Ff;
  // every assertion in this module runs on ref_clk and sleeps through reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstN);

  ////////////////////////////////////////////////////////////////////////////
  eepec_prog_s progFf;
  eepec_test_s testFf;
  eepec_latch_s latchFf;
  logic [4:0] guardFf;
  logic lockFf, lockWrittenFf;
  logic wrCfg, wrGrd, wrTst, wrPrg;
  eepec_prog_s wp;

  assign wrCfg = regWrite && regAddr == `EEPEC_OFS_CONFIG;
  assign wrGrd = regWrite && regAddr == `EEPEC_OFS_GUARD;
  assign wrTst = regWrite && regAddr == `EEPEC_OFS_TEST;
  assign wrPrg = regWrite && regAddr == `EEPEC_OFS_PROG;
  assign wp = eepec_prog_s'(regWdata);

  // guard lock: once in normal mode, freely in special mode
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      lockFf <= 1'b0;
      lockWrittenFf <= 1'b0;
    end else if (wrCfg && (!special_mode_n || !lockWrittenFf)) begin
      lockFf <= regWdata[`EEPEC_CFG_LOCK];
      lockWrittenFf <= 1'b1;
    end
  end

  // block guard bits frozen while voltage applied or locked
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      guardFf <= `EEPEC_GRD_RESET;
    end else if (wrGrd && !progFf.voltageApply && !lockFf) begin
      guardFf <= regWdata[4:0];
    end
  end

  // test bits only accepted in special mode; forced clear in normal mode
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      testFf <= '0;
    end else if (special_mode_n) begin
      testFf <= '0;
    end else if (wrTst) begin
      testFf <= eepec_test_s'(regWdata & `EEPEC_TST_MASK);
    end
  end

  // program control register with its interlocks
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      progFf <= eepec_prog_s'(`EEPEC_PRG_RESET);
    end else if (wrPrg) begin
      if (!progFf.voltageApply) begin
        // fields may be written together or in any order
        progFf.byteSel <= wp.byteSel;
        progFf.rowSel <= wp.rowSel;
        progFf.eraseSel <= wp.eraseSel;
        progFf.latchArm <= wp.latchArm;
        if (!lockFf)
          progFf.bulkGuard <= wp.bulkGuard;
      end
      // voltage needs latch-arm already set before this write
      progFf.voltageApply <= wp.voltageApply && progFf.latchArm;
    end
  end

  // address/data latch: every armed array write reloads, held under voltage
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      latchFf <= '0;
    end else if (arrayWrite && progFf.latchArm && !progFf.voltageApply) begin
      // misaligned word: all 16 data bits are taken but the wide flag is cleared
      latchFf.addr <= arrayAddr;
      latchFf.data <= arrayWdata;
      latchFf.wide <= arrayWide && !arrayAddr[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [4:0] blockOf(input logic [15:0] a);
    logic [15:0] off;
    off = a - `EEPEC_ARRAY_BASE;
    if (off[9:8] == 2'h0) blockOf = 5'h10;
    else if (off[9:8] == 2'h1) blockOf = 5'h08;
    else if (!off[7]) blockOf = 5'h04;
    else if (!off[6]) blockOf = 5'h02;
    else blockOf = 5'h01;
  endfunction

  logic testRows, eraseWide;
  eepec_size_e sizeSel;
  assign testRows = testFf.oddRowBulk || testFf.evenRowBulk;
  always_comb begin
    if (!progFf.eraseSel)
      sizeSel = EEPEC_SZ_NONE;
    else if (progFf.byteSel)
      sizeSel = EEPEC_SZ_BYTE;
    else if (progFf.rowSel)
      sizeSel = EEPEC_SZ_ROW;
    else
      sizeSel = EEPEC_SZ_BULK;
  end
  assign eraseWide = sizeSel == EEPEC_SZ_BULK || sizeSel == EEPEC_SZ_ROW;

  // protection: guard bits for erase size, block bits for the latched address
  always_comb begin
    opBlocked = 1'b0;
    if (eraseWide && progFf.bulkGuard)
      opBlocked = 1'b1;
    if (sizeSel == EEPEC_SZ_BULK && |guardFf)
      opBlocked = 1'b1;
    else if (|(blockOf(latchFf.addr) & guardFf) && !testRows)
      opBlocked = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // stop mode drops the high voltage but the control bit stays set
  logic hvOn;
  assign hvOn = progFf.voltageApply && !stopMode && !opBlocked;
  assign hvEnable = hvOn;
  assign pumpEnable = hvOn && !testFf.pumpDisable;
  assign pumpRampEnable = !testFf.pumpRampDisable;
  assign marginTest = testFf.voltageHeadroomTest;
  assign pumpMonitor = testFf.pumpMonitorOut;
  assign oddRowSel = testFf.oddRowBulk;
  assign evenRowSel = testFf.evenRowBulk;
  assign opErase = progFf.eraseSel;
  // byte erase outside test mode targets only the latched location
  assign opSize = testRows ? EEPEC_SZ_BULK : sizeSel;
  assign arrayReadBlock = progFf.latchArm;
  assign latchOut = latchFf;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `EEPEC_OFS_CONFIG: regRdata <= {6'h00, lockFf, 1'b0};
        `EEPEC_OFS_GUARD: regRdata <= {3'h0, guardFf};
        `EEPEC_OFS_TEST: regRdata <= testFf;
        `EEPEC_OFS_PROG: regRdata <= progFf;
        default: regRdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence armedS;
    progFf.latchArm;
  endsequence
  sequence unarmedS;
    !progFf.latchArm;
  endsequence
  sequence applyWrS;
    wrPrg && wp.voltageApply;
  endsequence
  // array write that the latch is allowed to take
  sequence latchWrS;
    arrayWrite && progFf.latchArm && !progFf.voltageApply;
  endsequence

  pgm_needs_arm_a: assert property (
    unarmedS ##0 applyWrS |=> !progFf.voltageApply)
    else $error("voltage applied without prior arm");
  pgm_sets_a: assert property (
    armedS ##0 applyWrS |=> progFf.voltageApply)
    else $error("voltage not applied after armed write");
  frozen_fields_a: assert property (
    progFf.voltageApply |=> $stable(progFf[7:1]))
    else $error("fields changed under voltage");
  latch_hold_a: assert property (
    progFf.voltageApply |=> $stable(latchFf))
    else $error("latch changed under voltage");
  latch_load_a: assert property (
    latchWrS |=> latchFf.addr == $past(arrayAddr))
    else $error("armed array write not latched");
  wide_align_a: assert property (
    latchWrS ##0 arrayAddr[0] |=> !latchFf.wide)
    else $error("misaligned word latched as word");
  test_normal_a: assert property (
    special_mode_n |=> testFf == '0)
    else $error("test bits set in normal mode");
  test_write_a: assert property (
    !special_mode_n && wrTst |=>
      testFf == ($past(regWdata) & `EEPEC_TST_MASK))
    else $error("test write lost in special mode");
  lock_once_a: assert property (
    special_mode_n && lockWrittenFf |=> $stable(lockFf))
    else $error("guard lock rewritten in normal mode");
  guard_frozen_a: assert property (
    progFf.voltageApply || lockFf |=> $stable(guardFf))
    else $error("block guard changed while frozen");
  bulk_lock_a: assert property (
    lockFf |=> $stable(progFf.bulkGuard))
    else $error("bulk guard changed while locked");
  stop_hv_a: assert property (
    stopMode |-> !hvEnable)
    else $error("high voltage during stop");
  hv_off_a: assert property (
    !progFf.voltageApply |-> !hvEnable)
    else $error("high voltage without apply bit");
  guard_refuse_a: assert property (
    progFf.bulkGuard && eraseWide |-> !hvEnable)
    else $error("guarded erase got voltage");
  blocked_hv_a: assert property (
    opBlocked |-> !hvEnable)
    else $error("protected block got voltage");
  ignore_fields_a: assert property (
    !progFf.eraseSel |-> opSize == EEPEC_SZ_NONE || testRows)
    else $error("size decoded without erase");
  read_block_a: assert property (
    progFf.latchArm |-> arrayReadBlock)
    else $error("array readable while armed");
  pump_off_a: assert property (
    testFf.pumpDisable |-> !pumpEnable)
    else $error("pump on while disabled");
  pump_run_a: assert property (
    hvEnable && !testFf.pumpDisable |-> pumpEnable)
    else $error("pump off during program/erase");
endmodule

// ===== eepec_pkg.sv
// Purpose: types shared by the eeprom program/erase controller
// Assumes: nothing
// Notes: register values travel as packed structs
package eepec_pkg;
  typedef enum logic [3:0] {
    EEPEC_SZ_NONE = 4'h1,
    EEPEC_SZ_BULK = 4'h2,
    EEPEC_SZ_ROW = 4'h4,
    EEPEC_SZ_BYTE = 4'h8
  } eepec_size_e;
  typedef struct packed {
    logic bulkGuard;
    logic [1:0] spare;
    logic byteSel;
    logic rowSel;
    logic eraseSel;
    logic latchArm;
    logic voltageApply;
  } eepec_prog_s;
  typedef struct packed {
    logic oddRowBulk;
    logic evenRowBulk;
    logic voltageHeadroomTest;
    logic spare4;
    logic pumpDisable;
    logic pumpRampDisable;
    logic spare1;
    logic pumpMonitorOut;
  } eepec_test_s;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
    logic wide;
  } eepec_latch_s;
endpackage

// ===== eepec_regs.svh
// Purpose: offsets, field positions and reset values of the eeprom controller
// Assumes: byte-wide register port, four-byte register block
// Notes: array geometry counts kept here as well
`ifndef EEPEC_REGS_SVH
`define EEPEC_REGS_SVH
`define EEPEC_OFS_CONFIG 2'h0
`define EEPEC_OFS_GUARD 2'h1
`define EEPEC_OFS_TEST 2'h2
`define EEPEC_OFS_PROG 2'h3
// test register fields
`define EEPEC_TST_ODD 7
`define EEPEC_TST_EVEN 6
`define EEPEC_TST_VOLTAGE_HEADROOM_TEST 5
`define EEPEC_TST_CPD 3
`define EEPEC_TST_CPRD 2
`define EEPEC_TST_CPM 0
`define EEPEC_TST_MASK 8'hED
// program control fields
`define EEPEC_PRG_BULKG 7
`define EEPEC_PRG_BYTE 4
`define EEPEC_PRG_ROW 3
`define EEPEC_PRG_ERASE 2
`define EEPEC_PRG_LAT 1
`define EEPEC_PRG_PGM 0
`define EEPEC_PRG_RESET 8'h80
// configuration fields
`define EEPEC_CFG_LOCK 1
// guard register reset: all blocks protected
`define EEPEC_GRD_RESET 5'h1F
// array geometry
`define EEPEC_ROW_BYTES 32
`define EEPEC_ARRAY_BASE 16'h0D00
`endif

// ===== tb_top.sv
// Purpose: self-checking bench for the eeprom program/erase control
// Assumes: register index 0 config, 1 block guard, 2 test, 3 program
// Notes: inputs change at the falling edge; no timer, so waits are free
`timescale 1ns/1ps
module tb_top import eepec_pkg::*;;
  ////////////////////////////////////////////////////////////////////////////
  logic ref_clk = 0, reset_n = 0, specialModeN = 1, stopMode = 0;
  logic regWrite = 0, regRead = 0, arrayWrite = 0, arrayWide = 0;
  logic [1:0] regAddr = 0;
  logic [7:0] regWdata = 0, regRdata, v;
  logic [15:0] arrayAddr = 0, arrayWdata = 0;
  logic arrayReadBlock, hvEnable, pumpEnable, pumpRampEnable, marginTest;
  logic pumpMonitor, opErase, oddRowSel, evenRowSel, opBlocked;
  eepec_size_e opSize;
  eepec_latch_s latchOut;
  int errors = 0, num_checks = 0;
  always #20 ref_clk = ~ref_clk;
  eepec_ctrl u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .special_mode_n(specialModeN), .stopMode(stopMode),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .arrayWrite(arrayWrite),
    .arrayWide(arrayWide), .arrayAddr(arrayAddr), .arrayWdata(arrayWdata),
    .arrayReadBlock(arrayReadBlock), .hvEnable(hvEnable),
    .pumpEnable(pumpEnable), .pumpRampEnable(pumpRampEnable),
    .marginTest(marginTest), .pumpMonitor(pumpMonitor), .opErase(opErase),
    .opSize(opSize), .oddRowSel(oddRowSel), .evenRowSel(evenRowSel),
    .opBlocked(opBlocked), .latchOut(latchOut));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [32:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one idle cycle between requests keeps each strobe a clean pulse
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regWrite = 1; regAddr = a; regWdata = d;
    @(negedge ref_clk);
    regWrite = 0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    regRead = 1; regAddr = a;
    @(negedge ref_clk);
    regRead = 0; d = regRdata;
  endtask
  task automatic aw(input logic [15:0] a, d, input logic w);
    @(negedge ref_clk);
    arrayWrite = 1; arrayAddr = a; arrayWdata = d; arrayWide = w;
    @(negedge ref_clk);
    arrayWrite = 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(3, v); chk("prog", v, 8'h80);
    rd(1, v); chk("guard", v, 8'h1F);
    chk("block", arrayReadBlock, 0);
    wr(2, 8'hFF); rd(2, v); chk("test", v, 8'h00);
    chk("margin", marginTest, 0);
  endtask
  task automatic t_sequence();
    wr(1, 8'h00); wr(3, 8'h03); rd(3, v); chk("prog", v, 8'h02);
    chk("block", arrayReadBlock, 1);
    aw(16'h0D10, 16'h1234, 1);
    chk("latch", latchOut, {16'h0D10, 16'h1234, 1'b1});
    wr(3, 8'h03); chk("hv", hvEnable, 1);
    chk("pump", pumpEnable, 1);
    chk("ramp", pumpRampEnable, 1);
    chk("mon", pumpMonitor, 0);
    wr(3, 8'h9F); rd(3, v); chk("frozen", v, 8'h03);
    aw(16'h0D20, 16'h5555, 0);
    chk("latch", latchOut, {16'h0D10, 16'h1234, 1'b1});
    wr(1, 8'h1F); rd(1, v); chk("guard", v, 8'h00);
    stopMode = 1; @(negedge ref_clk); chk("stop", hvEnable, 0);
    rd(3, v); chk("prog", v, 8'h03);
    stopMode = 0; @(negedge ref_clk); chk("resume", hvEnable, 1);
    repeat (100) @(negedge ref_clk);
    chk("hold", hvEnable, 1);
    wr(3, 8'h02); chk("hv", hvEnable, 0);
    aw(16'h0D22, 16'h00AB, 0);
    chk("latch", latchOut, {16'h0D22, 16'h00AB, 1'b0});
    wr(3, 8'h00); chk("block", arrayReadBlock, 0);
  endtask
  task automatic t_sizes();
    logic [7:0] pv [5] = '{8'h04, 8'h0C, 8'h14, 8'h1C, 8'h18};
    eepec_size_e ex [5] = '{EEPEC_SZ_BULK, EEPEC_SZ_ROW, EEPEC_SZ_BYTE,
      EEPEC_SZ_BYTE, EEPEC_SZ_NONE};
    foreach (pv[i]) begin
      wr(3, pv[i]);
      chk("size", opSize, ex[i]);
      chk("erase", opErase, pv[i][2]);
    end
    wr(3, 8'h02); wr(3, 8'h06); rd(3, v); chk("order", v, 8'h06);
    wr(3, 8'h02); aw(16'h0D31, 16'hBEEF, 1);
    chk("wide", latchOut, {16'h0D31, 16'hBEEF, 1'b0});
    wr(3, 8'h00);
  endtask
  task automatic t_guard();
    wr(1, 8'h10); wr(3, 8'h02); aw(16'h0D40, 16'h0000, 0); wr(3, 8'h03);
    chk("blocked", opBlocked, 1);
    chk("hv", hvEnable, 0);
    wr(3, 8'h00); wr(3, 8'h00); wr(1, 8'h00);
    wr(3, 8'h86); aw(16'h0E00, 16'h0000, 0); wr(3, 8'h87);
    chk("bulk", opBlocked, 1);
    wr(3, 8'h00); wr(3, 8'h00); rd(3, v); chk("prog", v, 8'h00);
  endtask
  task automatic t_lock();
    wr(0, 8'h02); wr(0, 8'h00); rd(0, v); chk("lock", v[1], 1);
    wr(3, 8'h80); rd(3, v); chk("prog", v, 8'h00);
    wr(1, 8'h1F); rd(1, v); chk("guard", v, 8'h00);
  endtask
  task automatic t_special();
    specialModeN = 0;
    wr(0, 8'h00); rd(0, v); chk("lock", v[1], 0);
    wr(2, 8'hED); rd(2, v); chk("test", v, 8'hED);
    chk("margin", marginTest, 1);
    chk("mon", pumpMonitor, 1);
    chk("odd", oddRowSel, 1);
    chk("even", evenRowSel, 1);
    chk("ramp", pumpRampEnable, 0);
    chk("rows", opSize, EEPEC_SZ_BULK);
    wr(3, 8'h02); aw(16'h0D60, 16'h0001, 0); wr(3, 8'h03);
    chk("hv", hvEnable, 1);
    chk("pump", pumpEnable, 0);
    wr(3, 8'h00); wr(3, 8'h00);
    specialModeN = 1;
    wr(2, 8'hFF); rd(2, v); chk("test", v, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge ref_clk);
    reset_n = 1;
    repeat (3) @(negedge ref_clk);
    t_reset();
    t_sequence();
    t_sizes();
    t_guard();
    t_lock();
    t_special();
    test_done();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    test_done();
  end
endmodule
